// file: design/cdgc_defines.svh
`ifndef CDGC_DEFINES_SVH
`define CDGC_DEFINES_SVH

// socket register space address of the control register
`define CDGC_REG_ADDR 12'h816
`define CDGC_ADDR_W 12
`define CDGC_DATA_W 8

// field positions
`define CDGC_SW_TRIG_BIT 5
`define CDGC_RESUME_BIT 4
`define CDGC_INHIBIT_BIT 0

// reset values of the writable fields
`define CDGC_RESUME_RST 1'b0
`define CDGC_INHIBIT_RST 1'b0

// answer for an address that is not this register
`define CDGC_UNMAPPED_DATA 8'h00

// strobe falling-edge delay
`define CDGC_CLK_PERIOD_NS 20
`define CDGC_STROBE_DELAY_NS 60
`define CDGC_STROBE_DELAY_CYC \
  ((`CDGC_STROBE_DELAY_NS + `CDGC_CLK_PERIOD_NS - 1) / `CDGC_CLK_PERIOD_NS)

`endif

// file: design/cdgc_pkg.sv
package cdgc_pkg;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_active = 2'b10
  } strobe_state_t;

endpackage

// file: design/strobe_fall_delay.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdgc_defines.svh"

module strobe_fall_delay #(
  parameter int DELAY_CYC = `CDGC_STROBE_DELAY_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_req_n,
  input wire logic i_delay_en,
  output logic o_strobe_n
);
  import cdgc_pkg::*;

  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

  // refused while elaborating, before any clock runs
  if (DELAY_CYC < 1) begin : g_bad_delay
    $error("strobe delay must be at least one cycle");
  end

  strobe_state_t state;
  strobe_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_strobe_n;

  // rising edge always goes straight through; only the fall is held back
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (i_req_n) begin
      next_state = st_idle;
      next_cnt = '0;
    end else begin
      case (state)
        st_idle: begin
          next_cnt = '0;
          if (i_delay_en) begin
            next_state = st_wait;
          end else begin
            next_state = st_active;
          end
        end
        st_wait: begin
          if (cnt == LAST) begin
            next_state = st_active;
          end else begin
            next_cnt = cnt + CW'(1);
          end
        end
        st_active: begin
          next_state = st_active;
        end
        default: begin
          next_state = st_idle;
        end
      endcase
    end
    next_strobe_n = (next_state != st_active);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= st_idle;
      cnt <= '0;
      o_strobe_n <= 1'b1;
    end else if (i_clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      o_strobe_n <= next_strobe_n;
    end
  end

  a_delayed_no_fall: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && state == st_idle && !i_req_n && i_delay_en)
      |=> o_strobe_n)
    else $error("delayed strobe fell without delay");

  a_delay_expiry: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && state == st_wait && cnt == LAST && !i_req_n)
      |=> !o_strobe_n)
    else $error("strobe did not fall at end of delay");

  a_inhibit_direct: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && state == st_idle && !i_req_n && !i_delay_en)
      |=> !o_strobe_n)
    else $error("undelayed strobe did not fall next cycle");

  c_delayed_fall: cover property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    state == st_wait ##1 state == st_active);

endmodule
`default_nettype wire

// file: design/card_detect_general_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdgc_defines.svh"

module card_detect_general_control #(
  parameter int DELAY_CYC = `CDGC_STROBE_DELAY_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic [`CDGC_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [`CDGC_DATA_W-1:0] i_reg_wdata,
  output logic [`CDGC_DATA_W-1:0] o_reg_rdata,
  input wire logic i_card_detect_n,
  input wire logic i_cd_change_enable,
  input wire logic i_csc_to_irq,
  input wire logic i_we_req_n,
  input wire logic i_oe_req_n,
  input wire logic i_win_16bit,
  output logic o_csc_event,
  output logic o_csc_irq,
  output logic o_ring_indicate_output_n,
  output logic o_card_we_n,
  output logic o_card_oe_n
);
  import cdgc_pkg::*;

  // a zero-cycle delay would leave the wait state with no exit count
  if (DELAY_CYC < 1) begin : g_bad_delay
    $error("strobe delay must be at least one cycle");
  end

  logic resume_en;
  logic delay_inhibit;
  logic next_resume_en;
  logic next_delay_inhibit;
  logic [`CDGC_DATA_W-1:0] next_rdata;

  logic cd_meta;
  logic cd_sync;
  logic cd_last;
  logic next_csc_event;
  logic next_csc_irq;
  logic next_ring_n;

  logic hit;
  logic sw_trig;
  logic hw_change;
  logic any_change;
  logic strobe_delay_en;

  function automatic logic [`CDGC_DATA_W-1:0] pack_reg(input logic res,
                                                      input logic inh);
    logic [`CDGC_DATA_W-1:0] v;
    v = '0;
    v[`CDGC_RESUME_BIT] = res;
    v[`CDGC_INHIBIT_BIT] = inh;
    // trigger bit left zero on purpose
    v[`CDGC_SW_TRIG_BIT] = 1'b0;
    return v;
  endfunction

  assign hit = (i_reg_addr == `CDGC_REG_ADDR);
  assign sw_trig = hit && i_reg_wr && i_reg_wdata[`CDGC_SW_TRIG_BIT];
  // either edge of the synchronized card detect pin is a change
  assign hw_change = cd_sync ^ cd_last;
  assign any_change = sw_trig || hw_change;
  assign strobe_delay_en = !delay_inhibit && i_win_16bit;

  // register file
  always_comb begin
    next_resume_en = resume_en;
    next_delay_inhibit = delay_inhibit;
    next_rdata = o_reg_rdata;
    if (hit && i_reg_wr) begin
      next_resume_en = i_reg_wdata[`CDGC_RESUME_BIT];
      next_delay_inhibit = i_reg_wdata[`CDGC_INHIBIT_BIT];
    end
    if (i_reg_rd) begin
      if (hit) begin
        next_rdata = pack_reg(resume_en, delay_inhibit);
      end else begin
        next_rdata = `CDGC_UNMAPPED_DATA;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      resume_en <= `CDGC_RESUME_RST;
      delay_inhibit <= `CDGC_INHIBIT_RST;
      o_reg_rdata <= '0;
    end else if (i_clk_en) begin
      resume_en <= next_resume_en;
      delay_inhibit <= next_delay_inhibit;
      o_reg_rdata <= next_rdata;
    end
  end

  // status change routing; ring indicate assumed set up by software first
  always_comb begin
    next_csc_event = any_change;
    next_csc_irq = any_change && i_cd_change_enable
                   && i_csc_to_irq && !resume_en;
    next_ring_n = !(any_change && i_cd_change_enable && resume_en);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cd_meta <= 1'b1;
      cd_sync <= 1'b1;
      cd_last <= 1'b1;
      o_csc_event <= 1'b0;
      o_csc_irq <= 1'b0;
      o_ring_indicate_output_n <= 1'b1;
    end else if (i_clk_en) begin
      cd_meta <= i_card_detect_n;
      cd_sync <= cd_meta;
      cd_last <= cd_sync;
      o_csc_event <= next_csc_event;
      o_csc_irq <= next_csc_irq;
      o_ring_indicate_output_n <= next_ring_n;
    end
  end

  // one delay unit per strobe keeps write and read edges independent
  strobe_fall_delay #(
    .DELAY_CYC(DELAY_CYC)
  ) u_we_delay (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_req_n(i_we_req_n),
    .i_delay_en(strobe_delay_en),
    .o_strobe_n(o_card_we_n)
  );

  strobe_fall_delay #(
    .DELAY_CYC(DELAY_CYC)
  ) u_oe_delay (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_req_n(i_oe_req_n),
    .i_delay_en(strobe_delay_en),
    .o_strobe_n(o_card_oe_n)
  );

  a_reserved_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[3:1] == 3'h0)
    else $error("reserved bits read nonzero");

  a_trigger_event: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && sw_trig) |=> o_csc_event)
    else $error("software trigger gave no status change event");

  a_trigger_gated: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && !i_cd_change_enable)
      |=> !o_csc_irq && o_ring_indicate_output_n)
    else $error("interrupt without card detect change enable");

  a_trigger_reads_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && i_reg_rd && hit) |=> !o_reg_rdata[`CDGC_SW_TRIG_BIT])
    else $error("trigger bit read back as one");

  a_resume_readback: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && hit && i_reg_wr) ##1 (i_clk_en && hit && i_reg_rd && !i_reg_wr)
      |=> o_reg_rdata[`CDGC_RESUME_BIT]
          == $past(i_reg_wdata[`CDGC_RESUME_BIT], 2))
    else $error("resume enable did not read back as written");

  a_resume_blocks_irq: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && resume_en) |=> !o_csc_irq)
    else $error("irq raised while resume enabled");

  a_resume_rings: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && resume_en && i_cd_change_enable && sw_trig)
      |=> !o_ring_indicate_output_n)
    else $error("ring indicate missing on resume change");

  a_non16_undelayed: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn)
    (i_clk_en && !i_win_16bit && !i_we_req_n && o_card_we_n) |=> !o_card_we_n)
    else $error("strobe delayed outside a 16-bit window");

  a_reset_clear: assert property (@(posedge i_sys_clk)
    !i_resetn |-> (!resume_en && !delay_inhibit))
    else $error("writable bits not cleared in reset");

  c_sw_irq: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_csc_irq);
  c_ring: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !o_ring_indicate_output_n);
  c_hw_change: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_clk_en && hw_change);

endmodule
`default_nettype wire

// file: dv/card_model.sv
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input wire logic i_sys_clk,
  input wire logic i_insert,
  output logic o_card_detect_n
);
  // detect switch pulls the pin low only while the card is seated
  initial o_card_detect_n = 1'b1;
  always @(posedge i_sys_clk) begin
    o_card_detect_n <= !i_insert;
  end
endmodule
`default_nettype wire

// file: dv/card_detect_general_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module card_detect_general_control_tb_top;
  localparam int DLY = 3;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic en = 1'b0;
  logic route = 1'b0;
  logic we_req_n = 1'b1;
  logic oe_req_n = 1'b1;
  logic win16 = 1'b0;
  logic insert = 1'b0;
  logic ce = 1'b1;
  logic cd_n, ev, irq, ring_n, we_n, oe_n;
  logic [7:0] rdata;
  logic [31:0] lfsr = 32'hfd2948be;
  logic [7:0] last_rd = 8'h00;
  logic [7:0] regv = 8'h00;
  logic [7:0] d;
  logic [10:0] expq[$];
  logic acc_d = 1'b0;
  int n_fail = 0;
  int comparisons = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  card_detect_general_control #(
    .DELAY_CYC(DLY)
  ) u_card_detect_general_control (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(ce),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_card_detect_n(cd_n), .i_cd_change_enable(en),
    .i_csc_to_irq(route), .i_we_req_n(we_req_n), .i_oe_req_n(oe_req_n),
    .i_win_16bit(win16), .o_csc_event(ev), .o_csc_irq(irq),
    .o_ring_indicate_output_n(ring_n), .o_card_we_n(we_n), .o_card_oe_n(oe_n)
  );

  card_model u_card_model (
    .i_sys_clk(i_sys_clk), .i_insert(insert), .o_card_detect_n(cd_n)
  );

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one register access; the expected answer is noted for the monitor
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] v);
    logic hit, trig;
    hit = (a == 12'h816);
    // a frozen block keeps its idle outputs and the old read data
    trig = w && hit && v[5] && ce;
    if (!w && ce) last_rd = hit ? regv : 8'h00;
    expq.push_back({last_rd, trig, trig && en && route && !regv[4],
                    !(trig && en && regv[4])});
    if (w && hit && ce) regv = v & 8'h11;
    addr = a;
    wr = w;
    rd = !w;
    wdata = v;
    @(negedge i_sys_clk);
    wr = 1'b0;
    rd = 1'b0;
    // one idle edge so back-to-back calls never retoggle a strobe at once
    @(negedge i_sys_clk);
  endtask

  always @(posedge i_sys_clk) acc_d <= wr | rd;
  always @(negedge i_sys_clk) begin
    if (acc_d) begin
      chk({rdata, ev, irq, ring_n},
          expq.pop_front());
    end
  end

  task automatic strobe(input logic inh, input logic w16, input logic sel_oe);
    int n;
    acc(1'b1, 12'h816, {7'h00, inh});
    win16 = w16;
    if (sel_oe) oe_req_n = 1'b0;
    else we_req_n = 1'b0;
    n = 0;
    while ((sel_oe ? oe_n : we_n) !== 1'b0 && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(11'(n), (!inh && w16) ? 11'(DLY + 1) : 11'd1);
    if (n == 20) results();
    we_req_n = 1'b1;
    oe_req_n = 1'b1;
    @(negedge i_sys_clk);
    // the rising edge is never held back
    chk(11'(sel_oe ? oe_n : we_n), 11'd1);
    repeat (2) @(negedge i_sys_clk);
  endtask

  task automatic pin(input logic ins);
    int n;
    insert = ins;
    n = 0;
    while (ev !== 1'b1 && n < 10) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk({8'h00, ev, irq, ring_n},
        {8'h00, 1'b1, route && en && !regv[4], !(en && regv[4])});
    if (n == 10) results();
  endtask

  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    @(negedge i_sys_clk);
    acc(1'b0, 12'h816, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      lfsr = step(lfsr);
      en = lfsr[8];
      route = lfsr[9];
      d = lfsr[7:0];
      // keep resume steady across a trigger so routing is unambiguous
      if (d[5]) d[4] = regv[4];
      acc(1'b1, lfsr[10] ? 12'h816 : lfsr[23:12], d);
      acc(1'b0, lfsr[11] ? 12'h816 : 12'h817, 8'h00);
    end
    $display("test register and trigger done");
    for (int k = 0; k < 8; k++) strobe(k[0], k[1], k[2]);
    $display("test strobe delay done");
    en = 1'b1;
    route = 1'b1;
    acc(1'b1, 12'h816, 8'h00);
    pin(1'b1);
    // ring output taken as already configured before resume is set
    acc(1'b1, 12'h816, 8'h10);
    pin(1'b0);
    acc(1'b1, 12'h816, 8'h00);
    acc(1'b1, 12'h816, 8'h20);
    acc(1'b0, 12'h816, 8'h00);
    $display("test card change routing done");
    acc(1'b1, 12'h816, 8'h11);
    ce = 1'b0;
    acc(1'b1, 12'h816, 8'h00);
    acc(1'b0, 12'h816, 8'h00);
    ce = 1'b1;
    acc(1'b0, 12'h816, 8'h00);
    $display("test clock enable freeze done");
    i_resetn = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    regv = 8'h00;
    @(negedge i_sys_clk);
    acc(1'b0, 12'h816, 8'h00);
    $display("test reset in run done");
    results();
  end

  initial begin
    #1000000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
